// [rtl/scd_config_dump.v]
`timescale 1ns/100ps
`default_nettype none
`include "scd_map.vh"
module scd_config_dump #(
	parameter SLEEP_FRAMES = `SCD_SLEEP_FRAMES,
	parameter TEST_CYCLES = `SCD_SELF_TEST_CYCLES
) (
	input wire clk,
	input wire rstn,
	input wire [6:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_q,
	input wire frame_tick,
	input wire shutter_open,
	input wire motion_seen,
	input wire [5:0] pixel_value,
	input wire pixel_ready,
	output reg [7:0] pixel_addr_q,
	output wire led_on,
	output wire count_density_select,
	output wire asleep,
	output wire self_test_busy,
	output wire ram_defaults_load
);
	localparam ST_IDLE = 2'b00;
	localparam ST_TEST = 2'b01;
	localparam ST_DUMP = 2'b10;

	reg [7:0] config_q;
	reg [1:0] state_q;
	reg [15:0] test_cnt_q;
	reg [15:0] idle_frames_q;
	reg [7:0] res_hi_q;
	reg [7:0] res_lo_q;
	reg [7:0] lo_shadow_q;
	reg dump_start_q;
	reg soft_rst_q;
	wire [7:0] walk_addr;
	wire walk_done;
	wire cfg_wr;
	wire led_gating_select;
	wire image_readout_enable;
	wire stay_awake;

	assign cfg_wr = reg_wr && reg_addr == `SCD_ADDR_CONFIG;
	assign led_gating_select = config_q[`SCD_BIT_LED_GATING];
	assign count_density_select = config_q[`SCD_BIT_DENSITY]; // [R7]
	assign image_readout_enable = config_q[`SCD_BIT_READOUT];
	assign stay_awake = config_q[`SCD_BIT_AWAKE];
	assign led_on = !led_gating_select || shutter_open; // [R3]
	assign self_test_busy = state_q == ST_TEST;
	// self-test completion restores ram defaults, so host config comes after it
	assign ram_defaults_load = self_test_busy && test_cnt_q == 16'h0000; // [R5]
	assign asleep = !stay_awake && idle_frames_q >= SLEEP_FRAMES[15:0]; // [R9]

	scd_pixel_walker #(
		.ADDR_W(8)
	) u_walker (
		.clk(clk),
		.rstn(rstn && !soft_rst_q),
		.enable(state_q == ST_DUMP),
		.start(dump_start_q),
		.frame_tick(frame_tick && pixel_ready && !dump_start_q),
		.addr_q(walk_addr),
		.done_q(walk_done)
	);

	always @(posedge clk) begin
		if (!rstn || soft_rst_q) begin
			config_q <= `SCD_CONFIG_RESET; // [R1] [R10]
			soft_rst_q <= 1'b0;
		end else if (cfg_wr) begin
			// reset, self-test and reserved bits are never stored
			config_q <= reg_wdata & `SCD_CONFIG_WMASK; // [R2] [R4] [R22]
			soft_rst_q <= reg_wdata[`SCD_BIT_SOFT_RESET]; // [R1]
		end else if (ram_defaults_load) begin
			config_q <= `SCD_CONFIG_RESET; // [R5]
		end
	end

	always @(posedge clk) begin
		if (!rstn || soft_rst_q) begin
			state_q <= ST_IDLE;
			test_cnt_q <= 16'h0000;
			dump_start_q <= 1'b0;
		end else begin
			dump_start_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (cfg_wr && reg_wdata[`SCD_BIT_SELF_TEST]) begin
						state_q <= ST_TEST; // [R4]
						test_cnt_q <= TEST_CYCLES[15:0] - 16'h0001;
					end else if (image_readout_enable) begin
						state_q <= ST_DUMP; // [R8]
						dump_start_q <= 1'b1;
					end
				end
				ST_TEST: begin
					if (test_cnt_q == 16'h0000) begin
						state_q <= ST_IDLE;
					end else begin
						test_cnt_q <= test_cnt_q - 16'h0001;
					end
				end
				ST_DUMP: begin
					if (!image_readout_enable) begin
						state_q <= ST_IDLE; // [R8]
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// result pair is written as one unit so hi and lo always match
	always @(posedge clk) begin
		if (ram_defaults_load) begin
			res_hi_q <= `SCD_CRC_HI; // [R13] [R11] [R23]
			res_lo_q <= `SCD_CRC_LO;
		end else if (state_q == ST_DUMP && !walk_done) begin
			// pixel_value belongs to pixel_addr_q, not to the walker's newer address
			res_hi_q <= pixel_addr_q; // [R14] [R15] [R23]
			res_lo_q <= {!pixel_ready, 1'b0, pixel_value}; // [R16] [R20]
		end
	end

	always @(posedge clk) begin
		if (!rstn || soft_rst_q) begin
			pixel_addr_q <= 8'h00;
		end else begin
			pixel_addr_q <= walk_addr;
		end
	end

	// lower byte is frozen when the upper byte is read, so a dump step between reads cannot split the pair
	always @(posedge clk) begin
		if (!rstn) begin
			lo_shadow_q <= 8'h00;
		end else if (reg_rd && reg_addr == `SCD_ADDR_RES_HI) begin
			lo_shadow_q <= res_lo_q; // [R23]
		end
	end

	// saturating idle-frame count; any motion wakes the sensor
	always @(posedge clk) begin
		if (!rstn || soft_rst_q || motion_seen || stay_awake) begin
			idle_frames_q <= 16'h0000;
		end else if (frame_tick && idle_frames_q < SLEEP_FRAMES[15:0]) begin
			idle_frames_q <= idle_frames_q + 16'h0001; // [R9]
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`SCD_ADDR_CONFIG: reg_rdata_q <= config_q & `SCD_CONFIG_WMASK; // [R2] [R22]
				`SCD_ADDR_RES_LO: reg_rdata_q <= lo_shadow_q; // [R23]
				`SCD_ADDR_RES_HI: reg_rdata_q <= res_hi_q;
				default: reg_rdata_q <= 8'h00; // [R22]
			endcase
		end
	end
endmodule
`default_nettype wire

// [rtl/scd_map.vh]
// Behaviour
// R1 - writing one to bit 7 restores every register and bit to power-up defaults; code leaves result pair, lower-byte shadow and read data unchanged
// R2 - soft-reset bit always reads back as zero
// R3 - bit 6 zero keeps LED on; one lights LED only while shutter open
// R4 - self-test bit runs tests, loads 16-bit CRC result; bit reads zero; code starts the test only from idle and ignores the bit during a dump
// R5 - self-test restores defaults; host configures only after test finishes
// R6 - host waits much longer than a normal access for self-test
// R7 - bit 4 selects 400 cpi when zero, 800 cpi when one
// R8 - bit 3 starts 256-pixel dump through result pair; clearing stops it
// R9 - sleep bit zero sleeps after one second idle at 1500 fps; one stays awake
// R10 - configuration register is read/write and resets to all zeros
// R11 - result pair at 0x0c/0x0d loaded only by self-test or dump
// R12 - host reads upper byte 0x0d before lower byte 0x0c
// R13 - passing self-test returns one of two fixed CRC values, e.g. FE D4
// R14 - during dump upper byte is pixel address, lower carries 6-bit value
// R15 - dump command first loads address and value of first pixel
// R16 - lower byte MSB high flags invalid data; host saves only when low
// R17 - after each valid sample advance to next pixel on following frame
// R18 - host clears dump bit after collecting all pixels
// R19 - host sets always-awake so LED stays lit during dump
// R20 - pixel value is 6-bit intensity, zero black, 63 white
// R21 - pixel addresses 0x00 to 0xFF; low nibble row, high nibble column
// R22 - reserved bits 2 and 1 read zero; address 0x0b reads zero
// R23 - upper and lower result bytes captured as one coherent pair
`ifndef SCD_MAP_VH
`define SCD_MAP_VH
`define SCD_ADDR_CONFIG 7'h0A
`define SCD_ADDR_RSVD 7'h0B
`define SCD_ADDR_RES_LO 7'h0C
`define SCD_ADDR_RES_HI 7'h0D
`define SCD_BIT_SOFT_RESET 7
`define SCD_BIT_LED_GATING 6
`define SCD_BIT_SELF_TEST 5
`define SCD_BIT_DENSITY 4
`define SCD_BIT_READOUT 3
`define SCD_BIT_AWAKE 0
`define SCD_CONFIG_RESET 8'h00
`define SCD_CONFIG_WMASK 8'h59
`define SCD_CRC_HI 8'hFE
`define SCD_CRC_LO 8'hD4
`define SCD_INVALID_BIT 7
`define SCD_SLEEP_FRAMES 1500
`define SCD_SELF_TEST_CYCLES 64
`endif

// [rtl/scd_pixel_walker.v]
`timescale 1ns/100ps
`default_nettype none
`include "scd_map.vh"
// steps through the pixel array one address per frame while enabled
module scd_pixel_walker #(
	parameter ADDR_W = 8
) (
	input wire clk,
	input wire rstn,
	input wire enable,
	input wire start,
	input wire frame_tick,
	output reg [ADDR_W-1:0] addr_q,
	output reg done_q
);
	always @(posedge clk) begin
		if (!rstn || start || !enable) begin
			addr_q <= {ADDR_W{1'b0}}; // [R15] [R21]
			done_q <= 1'b0;
		end else if (frame_tick && !done_q) begin
			if (&addr_q) begin
				done_q <= 1'b1;
			end else begin
				addr_q <= addr_q + {{(ADDR_W-1){1'b0}}, 1'b1}; // [R17] [R21]
			end
		end
	end
endmodule
`default_nettype wire

// [verification/scd_pixel_array.sv]
`timescale 1ns/100ps
`default_nettype none
module scd_pixel_array (
	input wire logic clk,
	input wire logic slow,
	input wire logic [7:0] addr,
	output logic [5:0] value,
	output logic ready
);
	logic [1:0] ph = 2'b00;
	assign value = addr[5:0] ^ addr[7:2];
	// slow drops ready one cycle in three; period is coprime to the frame so ticks see both states
	always @(posedge clk) begin
		ph <= (ph == 2'b10) ? 2'b00 : ph + 2'b01;
		ready <= !slow || ph != 2'b00;
	end
endmodule
`default_nettype wire

// [verification/scd_props.sv]
`timescale 1ns/100ps
`default_nettype none
module scd_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic led_on,
	input wire logic count_density_select,
	input wire logic self_test_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_RST: assert property (disable iff (1'b0) !rstn |=> reg_rdata_q == 8'h00 && led_on && !self_test_busy)
		else $error("reset");
	AST_SRST: assert property (reg_wr && reg_addr == 7'h0A && reg_wdata[7] |-> ##2 !count_density_select && led_on)
		else $error("soft reset");
	AST_LED: assert property (reg_wr && reg_addr == 7'h0A && reg_wdata[7:5] == 3'b000 |=> led_on [*4])
		else $error("led");
	AST_DENS: assert property (reg_wr && reg_addr == 7'h0A && !reg_wdata[7] && !reg_wdata[5]
		|=> count_density_select == $past(reg_wdata[4]))
		else $error("density");
	AST_DRB: assert property (reg_rd && reg_addr == 7'h0A |=> reg_rdata_q[4] == count_density_select)
		else $error("density readback");
	AST_BUSY: assert property ($rose(self_test_busy) |-> self_test_busy [*8])
		else $error("busy");
	AST_RSVD: assert property (reg_rd && reg_addr == 7'h0B |=> reg_rdata_q == 8'h00)
		else $error("reserved");
	AST_CFGRB: assert property (reg_rd && reg_addr == 7'h0A |=> {reg_rdata_q[7], reg_rdata_q[5], reg_rdata_q[2:1]} == 4'h0)
		else $error("config zero bits");
endmodule
bind scd_config_dump scd_props u_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .led_on(led_on),
	.count_density_select(count_density_select), .self_test_busy(self_test_busy));
`default_nettype wire

// [verification/test_sensor_config_and_dump.sv]
`timescale 1ns/100ps
`default_nettype none
module test_sensor_config_and_dump;
	logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, frame_tick = 0, shutter_open = 0, motion_seen = 1, slow = 0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00, rd_q, fc = 8'h00, d;
	wire [7:0] reg_rdata_q, pixel_addr_q;
	wire [5:0] pixel_value;
	wire pixel_ready, led_on, count_density_select, asleep, self_test_busy, rdl;
	integer seed = 60, err_count = 0, n_tests = 0, i, n_rdl = 0;
	scd_config_dump #(.SLEEP_FRAMES(8)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .frame_tick(frame_tick),
		.shutter_open(shutter_open), .motion_seen(motion_seen), .pixel_value(pixel_value), .pixel_ready(pixel_ready),
		.pixel_addr_q(pixel_addr_q), .led_on(led_on), .count_density_select(count_density_select), .asleep(asleep),
		.self_test_busy(self_test_busy), .ram_defaults_load(rdl));
	scd_pixel_array u_pix (.clk(clk), .slow(slow), .addr(pixel_addr_q), .value(pixel_value), .ready(pixel_ready));
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		fc <= fc + 8'h01;
		frame_tick <= fc[3:0] == 4'hF;
		shutter_open <= fc[2];
		if (rdl === 1'b1) n_rdl <= n_rdl + 1;
	end
	function [5:0] pix(input [7:0] a);
		pix = a[5:0] ^ a[7:2];
	endfunction
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("Error %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wr(input [6:0] a, input [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [6:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1 rd_q = reg_rdata_q;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(7'h0A); chk("cfg", 8'h00, rd_q);
		rd(7'h0B); chk("rsvd", 8'h00, rd_q);
		for (i = 0; i < 6; i++) begin
			d = $random(seed) & 8'h5F;
			wr(7'h0A, d);
			rd(7'h0A); chk("cfg", d & 8'h59, rd_q);
			chk("dens", {7'h00, d[4]}, {7'h00, count_density_select});
		end
		wr(7'h0A, 8'h51);
		wr(7'h0A, 8'h80);
		rd(7'h0A); chk("srst", 8'h00, rd_q);
		$display("config test done");
		wr(7'h0A, 8'h20);
		for (i = 0; i < 300 && (i < 2 || self_test_busy !== 1'b0); i++) @(posedge clk);
		if (i == 300) begin
			err_count++;
			summarize;
		end
		chk("rdl", 8'h01, n_rdl[7:0]);
		rd(7'h0D); chk("crc_hi", 8'hFE, rd_q);
		rd(7'h0C); chk("crc_lo", 8'hD4, rd_q);
		rd(7'h0A); chk("cfg", 8'h00, rd_q);
		motion_seen <= 1'b0;
		repeat (400) @(posedge clk);
		#1 chk("sleep", 8'h01, {7'h00, asleep});
		$display("self test and sleep done");
		motion_seen <= 1'b1;
		slow <= 1'b1;
		wr(7'h0A, 8'h09);
		repeat (2) @(posedge clk);
		for (i = 0; i < 40; i++) begin
			rd(7'h0D); d = rd_q;
			rd(7'h0C);
			if (i == 0) chk("first", 8'h00, d);
			if (rd_q[7] === 1'b0) chk("pix", {2'b00, pix(d)}, {2'b00, rd_q[5:0]});
		end
		chk("advance", 8'h01, {7'h00, d > 8'h02});
		wr(7'h0A, 8'h00);
		$display("dump done");
		summarize;
	end
endmodule
`default_nettype wire
